// >>> rtl/linear_array_readout_sequencer.v
// Readout sequencer for a 64-element linear light sensor, with sample buffer
`include "pixel_seq_defs.vh"

module linear_array_readout_sequencer #(
  parameter PIX_N    = `PIX_COUNT,
  parameter IDX_W    = `PIX_IDX_W,
  parameter SMP_W    = `SAMPLE_W,
  parameter FDEPTH   = `FIFO_DEPTH,
  parameter FPTR_W   = `FIFO_PTR_W
) (
  input  wire             clk_i,               // Device clock, 100 MHz
  input  wire             rst_i,               // Synchronous reset, active high
  input  wire             start_i,             // Start pulse from controller pin
  input  wire [SMP_W-1:0] pixel_sample_i,      // Pixel level from sampler
  output wire             pixel_voltage_output_o,  // Pixel output drive level
  output wire             pixel_voltage_output_oe_o, // Output enable, high drives
  output wire [PIX_N-1:0] pixel_connect_o,     // One-hot pixel-to-amplifier switch
  output wire [PIX_N-1:0] integrator_reset_o,  // One-cycle integrator reset pulses
  output reg  [IDX_W-1:0] pixel_index_o,       // Pixel connected on the previous clock
  output reg              pixel_valid_o,       // A pixel was connected on the previous clock
  output reg  [31:0]      integration_cycles_o,// Last start-to-start spacing
  output wire             busy_o,              // Readout cycle in progress
  output wire [IDX_W+SMP_W-1:0] out_data_o,    // Buffered index and sample
  output wire             out_valid_o,         // Buffer holds a word
  input  wire             out_ready_i,         // Consumer takes word
  output wire             overrun_o            // Sample dropped, buffer full
);

  // Start pin comes from outside: three flip-flops, change counted when 2 and 3 agree
  reg start_s1;
  reg start_s2;
  reg start_s3;
  reg start_seen;

  always @(posedge clk_i) begin
    if (rst_i) begin
      start_s1   <= 1'b0;
      start_s2   <= 1'b0;
      start_s3   <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      start_s1 <= start_i;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      if (start_s2 == start_s3) begin
        start_seen <= start_s3;
      end
    end
  end

  // Accept only the rising side, so a long start still counts once
  reg  start_seen_d;
  wire start_edge = start_seen & ~start_seen_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      start_seen_d <= 1'b0;
    end else begin
      start_seen_d <= start_seen;
    end
  end

  // Token shift register: stage k high connects pixel k
  reg  [PIX_N-1:0] token;
  reg  [PIX_N-1:0] token_d;

  // A start is taken only when the previous cycle has ended, which is what
  // the controller already guarantees by spacing starts to clock 66 or later
  wire cycle_active = |token;
  wire take_start   = start_edge & ~cycle_active;
  wire [PIX_N-1:0] next_token = {token[PIX_N-2:0], take_start};

  always @(posedge clk_i) begin
    if (rst_i) begin
      token   <= {PIX_N{1'b0}};
      token_d <= {PIX_N{1'b0}};
    end else begin
      token   <= next_token;
      token_d <= token;
    end
  end

  // Connect switches follow the token directly
  assign pixel_connect_o = token;

  // Falling stage bit resets that pixel's integrator for one clock
  assign integrator_reset_o = token_d & ~token;

  // Output drives only while some stage holds the token; last shift leaves it idle
  assign busy_o                    = cycle_active;
  assign pixel_voltage_output_oe_o = cycle_active;
  assign pixel_voltage_output_o    = cycle_active & pixel_sample_i[SMP_W-1];

  // Index encoder: one-hot token to binary
  reg [IDX_W-1:0] enc_idx;
  integer k;

  always @* begin
    enc_idx = {IDX_W{1'b0}};
    for (k = 0; k < PIX_N; k = k + 1) begin
      if (token[k]) begin
        enc_idx = k[IDX_W-1:0];
      end
    end
  end

  // Registered index and valid for the companion sampler
  always @(posedge clk_i) begin
    if (rst_i) begin
      pixel_index_o <= `PIX_IDX_ZERO;
      pixel_valid_o <= 1'b0;
    end else begin
      pixel_index_o <= enc_idx;
      pixel_valid_o <= cycle_active;
    end
  end

  // Integration period: clocks between accepted starts, shown as a count
  reg [`PERIOD_W-1:0] period_cnt;
  reg                 period_armed;

  always @(posedge clk_i) begin
    if (rst_i) begin
      period_cnt           <= `PERIOD_ZERO;
      period_armed         <= 1'b0;
      integration_cycles_o <= `PERIOD_ZERO;
    end else if (take_start) begin
      if (period_armed) begin
        integration_cycles_o <= period_cnt;
      end
      period_cnt   <= `PERIOD_ONE;
      period_armed <= 1'b1;
    end else if (period_armed && period_cnt != {`PERIOD_W{1'b1}}) begin
      period_cnt <= period_cnt + `PERIOD_ONE;
    end
  end

  // Samples of connected pixels enter the buffer; full drops and flags overrun
  // since the sensor cannot be stalled mid-sweep
  wire                   fifo_in_ready;
  wire                   fifo_push = pixel_valid_o;
  reg                    overrun;
  reg  [SMP_W-1:0]       sample_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_q <= `SAMPLE_ZERO;
    end else begin
      sample_q <= pixel_sample_i;
    end
  end

  // Overrun is sticky until the next accepted start; a new drop wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
    end else if (fifo_push && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (take_start) begin
      overrun <= 1'b0;
    end
  end

  assign overrun_o = overrun;

  sample_fifo #(
    .WIDTH (IDX_W + SMP_W),
    .DEPTH (FDEPTH),
    .PTR_W (FPTR_W)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({pixel_index_o, sample_q}),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (out_data_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i)
  );

endmodule // linear_array_readout_sequencer

// >>> rtl/sample_fifo.v
// Small synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  input  wire             clk_i,     // System clock
  input  wire             rst_i,     // Synchronous reset, active high
  input  wire [WIDTH-1:0] in_data_i, // Write data
  input  wire             in_valid_i,// Write request
  output wire             in_ready_o,// Not full
  output wire [WIDTH-1:0] out_data_o,// Head word
  output wire             out_valid_o,// Not empty
  input  wire             out_ready_i // Reader takes head
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0]   fill;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  // Full and empty come straight from the fill count
  assign in_ready_o  = (fill != DEPTH[PTR_W:0]);
  assign out_valid_o = (fill != {(PTR_W+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  // Storage writes; no reset needed on the data array
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill level
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      fill   <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        fill <= fill + {{PTR_W{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        fill <= fill - {{PTR_W{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sample_fifo

// >>> shared/pixel_seq_defs.vh
// Constants for the linear array readout sequencer
`ifndef PIXEL_SEQ_DEFS_VH
`define PIXEL_SEQ_DEFS_VH

`define PIX_COUNT        64
`define PIX_IDX_W        6
`define PIX_LAST_IDX     6'h3f
`define PIX_IDX_ZERO     6'h00
`define PIX_IDX_ONE      6'h01
`define SAMPLE_W         12
`define SAMPLE_ZERO      12'h000
`define FIFO_DEPTH       8
`define FIFO_PTR_W       3
`define PERIOD_W         32
`define PERIOD_ZERO      32'h0000_0000
`define PERIOD_ONE       32'h0000_0001

`endif

// >>> testbench/linear_array_readout_sequencer_bench.sv
// Self-checking bench for the readout sequencer
module linear_array_readout_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, out_ready_i = 1'b0;
  logic        start_i, busy_o, out_valid_o, overrun_o;
  logic [11:0] pixel_sample_i = 12'h000, smp;
  logic [31:0] integration_cycles_o;
  logic [17:0] out_data_o;
  int          err_count = 0, tests_run = 0, exp_idx = 0, prev_gap = 0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  start_ctrl start_ctrl_inst (.clk_i(clk_i), .go_i(go), .start_o(start_i));
  linear_array_readout_sequencer linear_array_readout_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .pixel_sample_i(pixel_sample_i),
    .pixel_voltage_output_o(), .pixel_voltage_output_oe_o(), .pixel_connect_o(), .integrator_reset_o(),
    .pixel_index_o(), .pixel_valid_o(), .integration_cycles_o(integration_cycles_o), .busy_o(busy_o),
    .out_data_o(out_data_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .overrun_o(overrun_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] word_of(input int k);
    return {14'h0000, 6'(k), smp};
  endfunction

  // Consumer pops and compares words in pixel order
  always @(posedge clk_i) begin
    if (!rst_i && out_valid_o && out_ready_i) begin
      chk(out_data_o, word_of(exp_idx));
      exp_idx++;
    end
  end

  // One sweep spanning gap cycles from start to start; stall fills the buffer
  task automatic sweep(input bit stall, input int gap);
    @(posedge clk_i);
    exp_idx = 0;
    smp = 12'($urandom);
    pixel_sample_i <= smp;
    out_ready_i <= !stall;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (gap - 11) @(posedge clk_i);
    #1;
    chk(overrun_o, stall);
    chk(exp_idx, stall ? 0 : 64);
    if (prev_gap != 0) chk(integration_cycles_o, prev_gap);
    @(posedge clk_i);
    out_ready_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    chk(exp_idx, stall ? 8 : 64);
    chk(out_valid_o, 0);
    prev_gap = gap;
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hc84b23e2));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    sweep(1'b0, 84);
    sweep(1'b1, 84);
    repeat (4) sweep(1'($urandom), 84 + $urandom % 32);
    // Reset in mid-sweep must stop the token
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(busy_o, 0);
    chk(out_valid_o, 0);
    // Release again; the next sweep must run as from power-up
    exp_idx = 0;
    prev_gap = 0;
    rst_i <= 1'b0;
    sweep(1'b0, 84);
    sweep(1'b0, 90);
    results();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule // linear_array_readout_sequencer_bench

// >>> testbench/readout_checker.sv
// Port assertions for the readout sequencer
module readout_checker #(
  parameter int PIX_N = 64
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             start_i,
  input wire logic [11:0]      pixel_sample_i,
  input wire logic             pixel_voltage_output_o,
  input wire logic             pixel_voltage_output_oe_o,
  input wire logic [PIX_N-1:0] pixel_connect_o,
  input wire logic [PIX_N-1:0] integrator_reset_o,
  input wire logic [5:0]       pixel_index_o,
  input wire logic             pixel_valid_o,
  input wire logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIX_N-1:0] prev;
  wire logic [PIX_N-1:0] fell;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Stages that dropped at the last edge owe an integrator reset now
  always @(posedge clk_i) begin
    prev <= rst_i ? '0 : pixel_connect_o;
  end
  assign fell = prev & ~pixel_connect_o;
  // Start must outlast the input filter before the token enters
  sequence s_take;
    !busy_o ##0 $rose(start_i) ##1 start_i [*2];
  endsequence
  AST_START: assert property (s_take |-> ##[1:4] pixel_connect_o[0])
    else $error("token did not enter");
  AST_ONEHOT: assert property (busy_o |-> $onehot(pixel_connect_o))
    else $error("token not one-hot");
  AST_SHIFT: assert property (busy_o && !pixel_connect_o[PIX_N-1] |=> pixel_connect_o == $past(pixel_connect_o) << 1)
    else $error("token did not shift");
  AST_CLEAR: assert property (integrator_reset_o == fell)
    else $error("integrator reset wrong");
  AST_END: assert property (pixel_connect_o[PIX_N-1] |=> !busy_o && !pixel_voltage_output_oe_o ##1 !pixel_valid_o)
    else $error("sweep did not end");
  AST_HIZ: assert property (pixel_voltage_output_oe_o == busy_o)
    else $error("output enable wrong");
  AST_LEVEL: assert property (pixel_voltage_output_o == (busy_o && pixel_sample_i[11]))
    else $error("output level wrong");
  AST_INDEX: assert property (busy_o |=> pixel_valid_o && prev[pixel_index_o])
    else $error("pixel index wrong");
endmodule // readout_checker

bind linear_array_readout_sequencer readout_checker #(.PIX_N(PIX_N)) readout_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .pixel_sample_i(pixel_sample_i),
  .pixel_voltage_output_o(pixel_voltage_output_o), .pixel_voltage_output_oe_o(pixel_voltage_output_oe_o),
  .pixel_connect_o(pixel_connect_o), .integrator_reset_o(integrator_reset_o),
  .pixel_index_o(pixel_index_o), .pixel_valid_o(pixel_valid_o), .busy_o(busy_o));

// >>> testbench/start_ctrl.sv
// Controller model driving the start input
module start_ctrl (
  input  wire logic clk_i,  // Device clock
  input  wire logic go_i,   // Bench asks for a sweep
  output wire logic start_o // Start level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] left = 2'h0;
  // Three high cycles clear the input filter; then low so one edge counts
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= 2'h3;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  assign start_o = (left != 2'h0);
endmodule // start_ctrl
